// ===== logic/icf_defs.svh
// Constants shared by the instruction fetch block.
`ifndef ICF_DEFS_SVH
`define ICF_DEFS_SVH
`define ICF_WORD_BYTES 4
`define ICF_LINE_BYTES 32
`define ICF_CACHE_MIN 512
`define ICF_CACHE_MAX 65536
`define ICF_TCM_MIN 1
`define ICF_TCM_MAX 4
`define ICF_LOW_MEM_LIMIT 32'h2000_0000
`define ICF_RESET_BASE 32'h0000_0000
`define ICF_RESET_OFS 32'h0000_0000
`define ICF_EXC_BASE 32'h0000_0000
`define ICF_EXC_OFS 32'h0000_0020
`define ICF_TLB_BASE 32'h0000_0000
`define ICF_TLB_OFS 32'h0000_0100
`define ICF_BRK_ADDR 32'h0000_0200
`define ICF_REG_CTRL 4'h0
`define ICF_REG_STATUS 4'h1
`define ICF_REG_RESETV 4'h2
`define ICF_REG_EXCV 4'h3
`define ICF_REG_TLBV 4'h4
`define ICF_REG_FILLS 4'h5
`define ICF_CTRL_INVAL 0
`define ICF_ST_BUSY 0
`define ICF_ST_VALID 1
`define ICF_ST_TCM 2
`endif

// ===== logic/icf_pkg.sv
// Types of the instruction fetch block.
package icf_pkg;
  typedef enum logic [1:0] {
    ICF_IDLE = 2'b00,
    ICF_REQ = 2'b01,
    ICF_WAIT = 2'b11,
    ICF_DONE = 2'b10
  } icf_state_t;
  typedef logic [31:0] icf_addr_t;
endpackage

// ===== logic/icf_fill_seq.sv
// Line fill address sequencer: ascending or critical word first with wrap.
`timescale 1ns/1ps
`default_nettype none
`include "icf_defs.svh"
module icf_fill_seq #(
  parameter int LINE_BYTES = `ICF_LINE_BYTES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire icf_pkg::icf_addr_t missAddr,
  input wire logic wordDone,
  output icf_pkg::icf_addr_t wordAddr,
  output logic lastWord,
  output logic firstWord
);
  import icf_pkg::*;
  localparam int WORDS = LINE_BYTES / `ICF_WORD_BYTES;
  localparam int IW = $clog2(WORDS);
  logic [IW-1:0] idx_q;
  logic [IW-1:0] cnt_q;
  logic [31:IW+2] line_q;
  wire logic [IW-1:0] critIdx = missAddr[IW+1:2];
  wire logic [IW-1:0] allOnes = {IW{1'b1}};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      idx_q <= '0;
      cnt_q <= '0;
      line_q <= '0;
    end else if (start) begin
      idx_q <= critIdx;
      cnt_q <= '0;
      line_q <= missAddr[31:IW+2];
    end else if (wordDone) begin
      // Wrap happens naturally as the index overflows past the last word.
      idx_q <= idx_q + 1'b1;
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign wordAddr = {line_q, idx_q, 2'b00};
  assign lastWord = (cnt_q == allOnes);
  assign firstWord = (cnt_q == '0);
endmodule
`default_nettype wire

// ===== logic/icf_fetch.sv
// Instruction cache with line fill, tightly coupled ports and vectors.
// Overview of operation
// - Reset vector is base plus offset, physical.
// - Exception vector is base plus offset, physical.
// - Fast TLB vector exists only with MMU.
// - MMU and MPU together are rejected.
// - With MMU, all vector bases lie low.
// - Cache size 512 bytes to 64K, or none.
// - No cache removes master, needs tightly coupled.
// - Burst option fills lines by one burst.
// - Line start fills ascending by four bytes.
// - Mid line fetches critical word, then wraps.
// - One to four tightly coupled instruction ports.
`timescale 1ns/1ps
`default_nettype none
`include "icf_defs.svh"
module icf_fetch #(
  parameter int CACHE_BYTES = 4096,
  parameter int LINE_BYTES = `ICF_LINE_BYTES,
  parameter bit BURST_EN = 1'b0,
  parameter bit MMU_EN = 1'b0,
  parameter bit MPU_EN = 1'b0,
  parameter int TCM_PORTS = 1,
  parameter logic [31:0] RESET_BASE = `ICF_RESET_BASE,
  parameter logic [31:0] RESET_OFS = `ICF_RESET_OFS,
  parameter logic [31:0] EXC_BASE = `ICF_EXC_BASE,
  parameter logic [31:0] EXC_OFS = `ICF_EXC_OFS,
  parameter logic [31:0] TLB_BASE = `ICF_TLB_BASE,
  parameter logic [31:0] TLB_OFS = `ICF_TLB_OFS,
  parameter logic [31:0] BRK_ADDR = `ICF_BRK_ADDR,
  parameter logic [31:0] TCM_BASE = 32'h1000_0000,
  parameter int TCM_BYTES = 4096
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fetchReq,
  input wire icf_pkg::icf_addr_t fetchAddr,
  output logic fetchValid,
  output logic [31:0] fetchData,
  output logic fetchBusy,
  output icf_pkg::icf_addr_t mRead,
  output logic mReadEn,
  output logic [3:0] mBurstCount,
  input wire logic mWaitReq,
  input wire logic mReadValid,
  input wire logic [31:0] mReadData,
  output logic [TCM_PORTS*32-1:0] tcmAddr,
  output logic [TCM_PORTS-1:0] tcmRead,
  input wire logic [TCM_PORTS*32-1:0] tcmData,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRData
);
  import icf_pkg::*;
  localparam logic [31:0] RESET_VEC = RESET_BASE + RESET_OFS;
  localparam logic [31:0] EXC_VEC = EXC_BASE + EXC_OFS;
  localparam logic [31:0] TLB_VEC = MMU_EN ? (TLB_BASE + TLB_OFS) : 32'h0000_0000;
  localparam bit HAS_CACHE = (CACHE_BYTES != 0);
  localparam int WORDS = LINE_BYTES / `ICF_WORD_BYTES;
  localparam int LINES = HAS_CACHE ? CACHE_BYTES / LINE_BYTES : 1;
  localparam int IW = $clog2(WORDS);
  localparam int LW = (LINES > 1) ? $clog2(LINES) : 1;
  localparam int TW = 32 - LW - IW - 2;
  // Build-time checks stop an illegal configuration at elaboration.
  if (MMU_EN && MPU_EN) begin : gBadUnits
    $error("Address translation and memory protection cannot coexist.");
  end
  if (MMU_EN && (RESET_BASE >= `ICF_LOW_MEM_LIMIT || EXC_BASE >= `ICF_LOW_MEM_LIMIT ||
      TLB_BASE >= `ICF_LOW_MEM_LIMIT || BRK_ADDR >= `ICF_LOW_MEM_LIMIT)) begin : gBadVec
    $error("Vector bases must lie in low physical memory.");
  end
  if (HAS_CACHE && (CACHE_BYTES < `ICF_CACHE_MIN || CACHE_BYTES > `ICF_CACHE_MAX))
      begin : gBadSize
    $error("Instruction cache size out of range.");
  end
  if (!HAS_CACHE && TCM_PORTS < `ICF_TCM_MIN) begin : gNoMem
    $error("Without a cache a tightly coupled memory is needed.");
  end
  if (TCM_PORTS > `ICF_TCM_MAX) begin : gBadTcm
    $error("Too many tightly coupled ports.");
  end
  function automatic logic inTcm(input logic [31:0] a, input int p);
    logic [31:0] lo;
    lo = TCM_BASE + 32'(p * TCM_BYTES);
    return (a >= lo) && (a < lo + 32'(TCM_BYTES));
  endfunction
  icf_state_t st_q, st_d;
  logic [31:0] data_q [LINES*WORDS];
  logic [TW-1:0] tag_q [LINES];
  logic [LINES-1:0] valid_q;
  logic [31:0] reqAddr_q;
  logic critSent_q;
  logic fetchValid_q;
  logic [31:0] fetchData_q;
  logic [31:0] mRead_q;
  logic mReadEn_q;
  logic [31:0] regRData_q;
  logic [TCM_PORTS-1:0] tcmPend_q;
  logic [15:0] fills_q;
  logic [TCM_PORTS*32-1:0] tcmAddr_q;
  logic [TCM_PORTS-1:0] tcmRead_q;
  logic busy_q;
  wire icf_addr_t seqAddr;
  wire logic seqLast;
  wire logic seqFirst;
  wire logic [LW-1:0] lineIdx = (LINES > 1) ? fetchAddr[LW+IW+1:IW+2] : '0;
  wire logic [TW-1:0] lineTag = fetchAddr[31:32-TW];
  wire logic [LW-1:0] fillLine = (LINES > 1) ? reqAddr_q[LW+IW+1:IW+2] : '0;
  wire logic [TCM_PORTS-1:0] tcmHit;
  for (genvar p = 0; p < TCM_PORTS; p++) begin : gHit
    assign tcmHit[p] = inTcm(fetchAddr, p);
  end
  wire logic anyTcm = |tcmHit;
  wire logic hit = HAS_CACHE && valid_q[lineIdx] && (tag_q[lineIdx] == lineTag);
  wire logic accept = fetchReq && (st_q == ICF_IDLE);
  wire logic missStart = accept && !anyTcm && HAS_CACHE && !hit;
  wire logic wordIn = (st_q == ICF_WAIT) && mReadValid;
  wire logic issueDone = (st_q == ICF_REQ) && !mWaitReq;
  wire logic ctrlWr = regWr && (regAddr == `ICF_REG_CTRL);
  wire logic invalidate = ctrlWr && regWData[`ICF_CTRL_INVAL];
  wire logic [IW-1:0] wordIdx = seqAddr[IW+1:2];
  // The word index wraps inside the line, so a fill never strays into its neighbour.
  wire icf_addr_t nextWord = {seqAddr[31:IW+2], IW'(wordIdx + 1'b1), 2'b00};
  wire logic [3:0] burstLen = BURST_EN ? 4'(WORDS) : 4'h1;
  icf_fill_seq #(
    .LINE_BYTES(LINE_BYTES)
  ) uSeq (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(missStart),
    .missAddr(fetchAddr),
    .wordDone(wordIn),
    .wordAddr(seqAddr),
    .lastWord(seqLast),
    .firstWord(seqFirst)
  );
  always_comb begin
    st_d = st_q;
    case (st_q)
      ICF_IDLE: begin
        if (missStart) begin
          st_d = ICF_REQ;
        end
      end
      ICF_REQ: begin
        if (issueDone) begin
          st_d = ICF_WAIT;
        end
      end
      ICF_WAIT: begin
        if (wordIn && seqLast) begin
          st_d = ICF_DONE;
        end else if (wordIn && !BURST_EN) begin
          st_d = ICF_REQ;
        end
      end
      ICF_DONE: st_d = ICF_IDLE;
      default: st_d = ICF_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= ICF_IDLE;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      busy_q <= (st_d != ICF_IDLE);
    end
  end
  // Storage is not reset; only the valid bits guard against stale content.
  always_ff @(posedge sys_clk) begin
    if (wordIn) begin
      data_q[{fillLine, wordIdx}] <= mReadData;
    end
    if (missStart) begin
      tag_q[lineIdx] <= lineTag;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      valid_q <= '0;
    end else begin
      if (invalidate) begin
        valid_q <= '0;
      end else if (missStart) begin
        valid_q[lineIdx] <= 1'b0;
      end
      // A fill ending beside an invalidate still marks its line; the set wins.
      if (st_q == ICF_DONE) begin
        valid_q[fillLine] <= 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mRead_q <= '0;
      mReadEn_q <= 1'b0;
    end else if (st_d == ICF_REQ && (st_q != ICF_REQ || mWaitReq)) begin
      mRead_q <= (st_q == ICF_IDLE) ? {fetchAddr[31:2], 2'b00} : seqAddr;
      mReadEn_q <= 1'b1;
      if (st_q == ICF_WAIT) begin
        mRead_q <= nextWord;
      end
    end else begin
      mReadEn_q <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reqAddr_q <= '0;
      critSent_q <= 1'b0;
      fetchValid_q <= 1'b0;
      fetchData_q <= '0;
      tcmPend_q <= '0;
      tcmAddr_q <= '0;
      tcmRead_q <= '0;
    end else begin
      fetchValid_q <= 1'b0;
      tcmPend_q <= '0;
      tcmRead_q <= '0;
      if (accept) begin
        reqAddr_q <= fetchAddr;
        critSent_q <= 1'b0;
      end
      if (accept && anyTcm) begin
        tcmRead_q <= tcmHit;
        tcmPend_q <= tcmHit;
        for (int p = 0; p < TCM_PORTS; p++) begin
          tcmAddr_q[p*32 +: 32] <= fetchAddr;
        end
      end else if (accept && hit) begin
        fetchValid_q <= 1'b1;
        fetchData_q <= data_q[{lineIdx, fetchAddr[IW+1:2]}];
      end
      if (|tcmPend_q) begin
        fetchValid_q <= 1'b1;
        for (int p = 0; p < TCM_PORTS; p++) begin
          if (tcmPend_q[p]) begin
            fetchData_q <= tcmData[p*32 +: 32];
          end
        end
      end
      if (wordIn && seqFirst && !critSent_q) begin
        fetchValid_q <= 1'b1;
        fetchData_q <= mReadData;
        critSent_q <= 1'b1;
      end
    end
  end
  wire logic [31:0] statusWord = {16'h0000, 13'h0000, anyTcm, |valid_q, st_q != ICF_IDLE};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRData_q <= '0;
      fills_q <= '0;
    end else begin
      if (st_q == ICF_DONE) begin
        fills_q <= fills_q + 16'h0001;
      end
      regRData_q <= '0;
      if (regRd) begin
        case (regAddr)
          `ICF_REG_STATUS: regRData_q <= statusWord;
          `ICF_REG_RESETV: regRData_q <= RESET_VEC;
          `ICF_REG_EXCV: regRData_q <= EXC_VEC;
          `ICF_REG_TLBV: regRData_q <= TLB_VEC;
          `ICF_REG_FILLS: regRData_q <= {16'h0000, fills_q};
          default: regRData_q <= '0;
        endcase
      end
    end
  end
  assign fetchValid = fetchValid_q;
  assign fetchData = fetchData_q;
  assign fetchBusy = busy_q;
  // With no cache the master port stays quiet for good.
  assign mRead = HAS_CACHE ? mRead_q : 32'h0000_0000;
  assign mReadEn = HAS_CACHE ? mReadEn_q : 1'b0;
  assign mBurstCount = burstLen;
  assign tcmAddr = tcmAddr_q;
  assign tcmRead = tcmRead_q;
  assign regRData = regRData_q;
endmodule
`default_nettype wire

// ===== bench/icf_fetch_monitor.sv
// Checker on the fetch block's ports.
`timescale 1ns/1ps
`default_nettype none
module icf_fetch_monitor #(
  parameter bit MMU_EN = 1'b0,
  parameter logic [31:0] RST_VEC = 32'h0000_0000,
  parameter logic [31:0] EXC_VEC = 32'h0000_0000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fetchReq,
  input wire icf_pkg::icf_addr_t fetchAddr,
  input wire logic fetchValid,
  input wire logic [31:0] fetchData,
  input wire logic fetchBusy,
  input wire icf_pkg::icf_addr_t mRead,
  input wire logic mReadEn,
  input wire logic mWaitReq,
  input wire logic mReadValid,
  input wire logic [31:0] mReadData,
  input wire logic [3:0] regAddr,
  input wire logic regRd,
  input wire logic [31:0] regRData
);
  import icf_pkg::*;
  logic [31:0] reqAddr_q;
  logic [31:0] nextA_q;
  logic [3:0] accCnt_q;
  logic [3:0] rcvCnt_q;
  wire acc = mReadEn && !mWaitReq;
  wire taken = fetchReq && !fetchBusy;
  // Counts restart on every taken request, so hits never leave stale fill state.
  always_ff @(posedge sys_clk) begin
    if (rst || taken) begin
      accCnt_q <= 4'h0;
      rcvCnt_q <= 4'h0;
    end else begin
      accCnt_q <= accCnt_q + 4'(acc);
      rcvCnt_q <= rcvCnt_q + 4'(mReadValid);
    end
    if (taken) reqAddr_q <= fetchAddr;
    if (acc) nextA_q <= {mRead[31:5], mRead[4:2] + 3'h1, 2'h0};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence crit_in;
    mReadValid && rcvCnt_q == 4'h0;
  endsequence
  sequence last_in;
    mReadValid && rcvCnt_q == 4'h7;
  endsequence
  chk_first_word: assert property (acc && accCnt_q == 4'h0 |->
    mRead == {reqAddr_q[31:2], 2'h0})
    else $error("fill did not start at the requested word");
  chk_wrap_step: assert property (acc && accCnt_q != 4'h0 |-> mRead == nextA_q)
    else $error("fill address out of order");
  chk_fill_len: assert property (acc |-> accCnt_q < 4'h8)
    else $error("more than one line of reads");
  chk_req_hold: assert property (mReadEn && mWaitReq |=> mReadEn && $stable(mRead))
    else $error("read request dropped while stalled");
  chk_crit_fwd: assert property (crit_in |=>
    fetchValid && fetchData == $past(mReadData))
    else $error("critical word not forwarded");
  chk_busy_drop: assert property (last_in |-> ##[1:3] !fetchBusy)
    else $error("fill did not finish after last word");
  chk_reset_vec: assert property (regRd && regAddr == 4'h2 |=> regRData == RST_VEC)
    else $error("reset vector wrong");
  chk_exc_vec: assert property (regRd && regAddr == 4'h3 |=> regRData == EXC_VEC)
    else $error("exception vector wrong");
  chk_tlb_vec: assert property (regRd && regAddr == 4'h4 && !MMU_EN |=>
    regRData == 32'h0)
    else $error("miss vector present without translation");
endmodule
bind icf_fetch icf_fetch_monitor #(.MMU_EN(MMU_EN), .RST_VEC(RESET_BASE + RESET_OFS),
  .EXC_VEC(EXC_BASE + EXC_OFS)) icf_fetch_monitor_i (.sys_clk(sys_clk), .rst(rst),
  .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchValid(fetchValid),
  .fetchData(fetchData), .fetchBusy(fetchBusy), .mRead(mRead), .mReadEn(mReadEn),
  .mWaitReq(mWaitReq), .mReadValid(mReadValid), .mReadData(mReadData),
  .regAddr(regAddr), .regRd(regRd), .regRData(regRData));
`default_nettype wire

// ===== bench/icf_mem_model.sv
// Memory slave answering instruction reads, optionally with wait states.
`timescale 1ns/1ps
`default_nettype none
module icf_mem_model (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic [31:0] mRead,
  input wire logic mReadEn,
  output logic mWaitReq = 1'b0,
  output logic mReadValid = 1'b0,
  output logic [31:0] mReadData = 32'h0
);
  logic [31:0] pend[$];
  // Idle data inverts every idle cycle, so it alternates between the last word and its inverse.
  always @(posedge sys_clk) begin
    if (pend.size() > 0 && !(slow && mWaitReq)) begin
      mReadValid <= 1'b1;
      mReadData <= pend.pop_front();
    end else begin
      mReadValid <= 1'b0;
      mReadData <= ~mReadData;
    end
    if (mReadEn && !mWaitReq) pend.push_back(mRead + 32'h1234_0000);
    mWaitReq <= slow && !mWaitReq;
  end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the instruction fetch block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import icf_pkg::*;
  localparam logic [31:0] RB = 32'h0000_1000;
  localparam logic [31:0] RO = 32'h0000_0040;
  localparam logic [31:0] EB = 32'h0000_2000;
  localparam logic [31:0] EO = 32'h0000_0020;
  logic sys_clk = 0, rst = 1, fetchReq = 0, slow = 0, regWr = 0, regRd = 0;
  logic fetchValid, fetchBusy, mReadEn, mWaitReq, mReadValid;
  icf_addr_t fetchAddr = 0, mRead;
  logic [31:0] fetchData, mReadData, regRData, regWData = 0, tcmAddr;
  logic [3:0] mBurstCount, regAddr = 0;
  logic [0:0] tcmRead;
  // The bench stands in for the tightly coupled memory, which answers in the read's own cycle.
  // Between reads it shows the inverse, so a word taken at the wrong time never matches.
  wire logic [31:0] tcmData = tcmRead[0] ? tcmAddr + 32'h1234_0000 : ~(tcmAddr + 32'h1234_0000);
  int err_total = 0, total_checks = 0, cyc = 0;
  logic [31:0] seen[$];
  always #25 sys_clk = ~sys_clk;
  icf_fetch #(.RESET_BASE(RB), .RESET_OFS(RO), .EXC_BASE(EB), .EXC_OFS(EO)) icf_fetch_i (
    .sys_clk(sys_clk), .rst(rst), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .fetchValid(fetchValid), .fetchData(fetchData), .fetchBusy(fetchBusy), .mRead(mRead),
    .mReadEn(mReadEn), .mBurstCount(mBurstCount), .mWaitReq(mWaitReq),
    .mReadValid(mReadValid), .mReadData(mReadData), .tcmAddr(tcmAddr), .tcmRead(tcmRead),
    .tcmData(tcmData), .regAddr(regAddr), .regWData(regWData), .regWr(regWr),
    .regRd(regRd), .regRData(regRData));
  icf_mem_model icf_mem_model_i (.sys_clk(sys_clk), .slow(slow), .mRead(mRead),
    .mReadEn(mReadEn), .mWaitReq(mWaitReq), .mReadValid(mReadValid), .mReadData(mReadData));
  // Cycle count for the time limit, and a log of the reads that the slave accepts.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (mReadEn && !mWaitReq) seen.push_back(mRead);
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(regRData, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  // Checks the returned word, the number of master reads and their order.
  task automatic fetch(input logic [31:0] a, input int nrd);
    int n;
    @(posedge sys_clk);
    seen.delete();
    fetchReq <= 1'b1;
    fetchAddr <= a;
    @(posedge sys_clk);
    fetchReq <= 1'b0;
    #1;
    for (n = 0; n < 99 && fetchValid !== 1'b1; n++) #50;
    chk({31'h0, fetchValid}, 32'h0000_0001);
    chk(fetchData, {a[31:2], 2'h0} + 32'h1234_0000);
    for (n = 0; n < 99 && fetchBusy !== 1'b0; n++) #50;
    chk({31'h0, fetchBusy}, 32'h0000_0000);
    chk(32'(seen.size()), 32'(nrd));
    for (n = 0; n < nrd && n < seen.size(); n++) begin
      chk(seen[n], {a[31:5], 3'(a[4:2] + n), 2'h0});
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h2, RB + RO);
    rd(4'h3, EB + EO);
    rd(4'h4, 32'h0);
    rd(4'hF, 32'h0);
    chk({28'h0, mBurstCount}, 32'h0000_0001);
    fetch(32'h0000_0400, 8);
    fetch(32'h0000_0408, 0);
    fetch(32'h0000_0848, 8);
    slow <= 1'b1;
    fetch(32'h0000_0C5C, 8);
    slow <= 1'b0;
    wr(4'h0, 32'h0000_0001);
    fetch(32'h0000_0404, 8);
    rd(4'h1, 32'h0000_0002);
    rd(4'h5, 32'h0000_0004);
    fetch(32'h1000_0010, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
